// ===== hdl/cte_top.sv
// Decided for this implementation: the AXI4-Lite slave port.
`include "cte_consts.svh"
`default_nettype none
module cte_top #(
  parameter int STAMP_CYC = `CTE_STAMP_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite write
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // event sources
  input wire logic [2:0] EVT_IN,
  input wire logic BAT_DROP,
  input wire logic TMP_DROP,
  input wire logic VDD_DROP,
  input wire logic OSC_STOP,
  input wire logic STAMP2_TRIG,
  input wire logic STAMP3_TRIG,
  // outputs
  output logic STAMP1_TRIG,
  output logic IRQ
);
  cte_reg_if rif(); // register access

  // register index to byte address
  function automatic logic [11:0] idx2addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // mapped address check, shared by reads and writes
  function automatic logic addr_ok(input logic [11:0] a);
    return a == idx2addr(`CTE_IDX_CFG) || a == idx2addr(`CTE_IDX_STB) ||
           a == idx2addr(`CTE_IDX_ENA) || a == idx2addr(`CTE_IDX_FLG) ||
           a == `CTE_A_CNT || a == `CTE_A_BST || a == `CTE_A_BIF ||
           a == `CTE_A_BCN || a == `CTE_A_IST || a == `CTE_A_ICL ||
           a == `CTE_A_IEN;
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  cte_axil u_axil (
    .clk(CLK), .rst(RST),
    .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
    .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
    .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
    .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
    .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
    .rif(rif)
  );

  logic [7:0] cfg_ff; // command action configuration
  logic [7:0] strobe_ff; // command strobe value
  logic [7:0] ena_ff; // event trigger enable
  logic [7:0] flg_ff; // event flag register
  logic [19:0] bcn_ff; // per-buffer interrupt counts
  logic [2:0] ist_ff; // interrupt status
  logic [2:0] ien_ff; // interrupt enable
  logic irq_ff; // registered interrupt line
  logic stamp_trig_ff; // capture trigger pulse
  cte_pkg::cte_state_t state_ff; // command sequencer
  logic [7:0] wait_ff; // stamp write countdown
  logic [2:0] evp_ff; // previous event input levels
  logic [5:0] evc_ff [3]; // event pulse counters
  logic [2:0] ev_edge; // event input rising edges
  logic [7:0] ev_vec; // all event sources in flag layout
  logic [7:0] nxt_flg; // next event flags
  logic [31:0] wdm; // write data merged per lane
  logic [31:0] cfg_wm, ena_wm, bcn_wm; // old register values merged with the write
  logic wr_cfg, wr_stb, wr_ena, wr_flg, wr_bif, wr_bcn, wr_icl, wr_ien;
  logic cmd_go; // command accepted this cycle
  logic stamp_done; // stamp data written
  logic cmd_done; // command finished
  logic [2:0] buf_clr; // per-buffer clear
  logic [2:0] buf_wr; // per-buffer entry write
  logic [2:0] bif_clr; // per-buffer flag clear
  logic [2:0] bif; // buffer interrupt flags
  logic [2:0] bif_set; // buffer interrupt flag set pulses
  logic [5:0] ptr1; // buffer one pointer
  logic [3:0] ptr2, ptr3; // buffer two and three pointers
  logic [2:0] full, empty, ovw; // buffer flags

  // write decode
  assign wdm = wmerge(32'h0000_0000, rif.wr_data, rif.wr_strb);
  assign cfg_wm = wmerge({24'h00_0000, cfg_ff}, rif.wr_data, rif.wr_strb);
  assign ena_wm = wmerge({24'h00_0000, ena_ff}, rif.wr_data, rif.wr_strb);
  assign bcn_wm = wmerge({12'h000, bcn_ff}, rif.wr_data, rif.wr_strb);
  assign rif.wr_ok = addr_ok(rif.wr_addr);
  assign wr_cfg = rif.wr_en && rif.wr_addr == idx2addr(`CTE_IDX_CFG);
  assign wr_stb = rif.wr_en && rif.wr_addr == idx2addr(`CTE_IDX_STB) && rif.wr_strb[0];
  assign wr_ena = rif.wr_en && rif.wr_addr == idx2addr(`CTE_IDX_ENA);
  assign wr_flg = rif.wr_en && rif.wr_addr == idx2addr(`CTE_IDX_FLG) && rif.wr_strb[0];
  assign wr_bif = rif.wr_en && rif.wr_addr == `CTE_A_BIF && rif.wr_strb[0];
  assign wr_bcn = rif.wr_en && rif.wr_addr == `CTE_A_BCN;
  assign wr_icl = rif.wr_en && rif.wr_addr == `CTE_A_ICL && rif.wr_strb[0];
  assign wr_ien = rif.wr_en && rif.wr_addr == `CTE_A_IEN && rif.wr_strb[0];

  // a strobe write while busy is ignored
  assign cmd_go = wr_stb && state_ff == cte_pkg::ST_IDLE;
  assign stamp_done = state_ff == cte_pkg::ST_STAMP && wait_ff == 8'h00;
  assign cmd_done = state_ff == cte_pkg::ST_CLEAR || stamp_done;
  // every enabled action is launched by the same write
  assign buf_clr = {3{cmd_go}} & cfg_ff[`CTE_B_BUFCLR +: 3];
  assign buf_wr = {STAMP3_TRIG, STAMP2_TRIG, stamp_done};
  assign bif_clr = {3{wr_bif}} & ~rif.wr_data[2:0];

  // configuration and enable registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= `CTE_RST8;
      ena_ff <= `CTE_RST8;
      bcn_ff <= 20'h0_0000;
      ien_ff <= 3'h0;
    end else begin
      if (wr_cfg) cfg_ff <= cfg_wm[7:0] & `CTE_CFG_MASK;
      if (wr_ena) ena_ff <= ena_wm[7:0] & `CTE_ENA_MASK;
      if (wr_bcn) bcn_ff <= bcn_wm[19:0];
      if (wr_ien) ien_ff <= rif.wr_data[2:0];
    end
  end

  // command sequencer and strobe value
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= cte_pkg::ST_IDLE;
      strobe_ff <= `CTE_RST8;
      wait_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        cte_pkg::ST_IDLE: begin
          if (cmd_go) begin
            // strobe holds a non-zero value while the command runs
            strobe_ff <= (wdm[7:0] != 8'h00) ? wdm[7:0] : 8'h01;
            wait_ff <= 8'(STAMP_CYC - 1);
            state_ff <= cfg_ff[`CTE_B_STAMP] ? cte_pkg::ST_STAMP : cte_pkg::ST_CLEAR;
          end
        end
        cte_pkg::ST_CLEAR: begin
          // clears took effect at the write, done in one cycle
          state_ff <= cte_pkg::ST_IDLE;
          strobe_ff <= `CTE_RST8;
        end
        cte_pkg::ST_STAMP: begin
          // stamp data and flags written, then release the strobe
          if (stamp_done) begin
            state_ff <= cte_pkg::ST_IDLE;
            strobe_ff <= `CTE_RST8;
          end else begin
            wait_ff <= wait_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= cte_pkg::ST_IDLE;
          strobe_ff <= `CTE_RST8;
        end
      endcase
    end
  end

  // capture trigger pulse to the first buffer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) stamp_trig_ff <= 1'b0;
    else stamp_trig_ff <= cmd_go && cfg_ff[`CTE_B_STAMP];
  end
  assign STAMP1_TRIG = stamp_trig_ff;

  // event input edges and pulse counters
  assign ev_edge = EVT_IN & ~evp_ff;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      evp_ff <= 3'h0;
      for (int i = 0; i < 3; i++) evc_ff[i] <= 6'h00;
    end else begin
      evp_ff <= EVT_IN;
      for (int i = 0; i < 3; i++) begin
        if (cmd_go && cfg_ff[`CTE_B_CNTCLR]) evc_ff[i] <= 6'h00;
        else if (ev_edge[i]) evc_ff[i] <= evc_ff[i] + 6'h01;
      end
    end
  end

  // event flags: set only when enabled, write 0 clears, set wins
  assign ev_vec = {ev_edge, 1'b0, BAT_DROP, TMP_DROP, VDD_DROP, OSC_STOP};
  always_comb begin
    nxt_flg = flg_ff;
    if (wr_flg) nxt_flg = flg_ff & rif.wr_data[7:0];
    nxt_flg = (nxt_flg | (ev_vec & ena_ff)) & `CTE_FLG_MASK;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) flg_ff <= `CTE_RST8;
    else flg_ff <= nxt_flg;
  end

  // interrupt status, write-one clear, set wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ist_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      ist_ff <= (ist_ff & ~({3{wr_icl}} & rif.wr_data[2:0])) |
                {|bif_set, cmd_done, |(ev_vec & ena_ff)};
      irq_ff <= |(ist_ff & ien_ff);
    end
  end
  assign IRQ = irq_ff;

  // time-stamp buffer status
  cte_buf #(.PW(6)) u_buf_one (
    .clk(CLK), .rst(RST), .clr(buf_clr[0]), .wr(buf_wr[0]),
    .int_cnt(bcn_ff[5:0]), .intf_clr(bif_clr[0]),
    .ptr(ptr1), .full(full[0]), .empty(empty[0]), .ovw(ovw[0]),
    .intf(bif[0]), .intf_set(bif_set[0])
  );
  cte_buf #(.PW(4)) u_buf_two (
    .clk(CLK), .rst(RST), .clr(buf_clr[1]), .wr(buf_wr[1]),
    .int_cnt(bcn_ff[11:8]), .intf_clr(bif_clr[1]),
    .ptr(ptr2), .full(full[1]), .empty(empty[1]), .ovw(ovw[1]),
    .intf(bif[1]), .intf_set(bif_set[1])
  );
  cte_buf #(.PW(4)) u_buf_three (
    .clk(CLK), .rst(RST), .clr(buf_clr[2]), .wr(buf_wr[2]),
    .int_cnt(bcn_ff[19:16]), .intf_clr(bif_clr[2]),
    .ptr(ptr3), .full(full[2]), .empty(empty[2]), .ovw(ovw[2]),
    .intf(bif[2]), .intf_set(bif_set[2])
  );

  // read mux
  always_comb begin
    rif.rd_ok = addr_ok(rif.rd_addr);
    rif.rd_data = 32'h0000_0000;
    unique case (rif.rd_addr)
      idx2addr(`CTE_IDX_CFG): rif.rd_data = {24'h00_0000, cfg_ff};
      idx2addr(`CTE_IDX_STB): rif.rd_data = {24'h00_0000, strobe_ff};
      idx2addr(`CTE_IDX_ENA): rif.rd_data = {24'h00_0000, ena_ff};
      idx2addr(`CTE_IDX_FLG): rif.rd_data = {24'h00_0000, flg_ff};
      `CTE_A_CNT: rif.rd_data = {8'h00, 2'b00, evc_ff[2], 2'b00, evc_ff[1],
                                 2'b00, evc_ff[0]};
      `CTE_A_BST: rif.rd_data = {5'h00, ovw[2], full[2], empty[2], ptr3,
                                 1'b0, ovw[1], full[1], empty[1], ptr2,
                                 1'b0, ovw[0], full[0], empty[0], 2'b00, ptr1};
      `CTE_A_BIF: rif.rd_data = {29'h0000_0000, bif};
      `CTE_A_BCN: rif.rd_data = {12'h000, bcn_ff};
      `CTE_A_IST: rif.rd_data = {29'h0000_0000, ist_ff};
      `CTE_A_IEN: rif.rd_data = {29'h0000_0000, ien_ff};
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  strobe_start_a: assert property (cmd_go |=> strobe_ff != 8'h00 &&
    state_ff != cte_pkg::ST_IDLE) else $error("strobe write did not start command");
  strobe_busy_a: assert property (cmd_go && cfg_ff[0] |-> ##1
    (strobe_ff != 8'h00)[*8] ##1 strobe_ff == 8'h00) else $error("stamp busy time wrong");
  strobe_idle_a: assert property (state_ff == cte_pkg::ST_IDLE |->
    strobe_ff == 8'h00) else $error("strobe non-zero while idle");
  count_clear_a: assert property (cmd_go && cfg_ff[7] |=> evc_ff[0] == 6'h00 &&
    evc_ff[1] == 6'h00 && evc_ff[2] == 6'h00) else $error("counters not cleared");
  buf_clear_a: assert property (cmd_go && cfg_ff[4] |=> ptr1 == 6'h00 &&
    !full[0] && !ovw[0] && empty[0]) else $error("buffer one not cleared");
  stamp_trig_a: assert property (cmd_go |=> STAMP1_TRIG == $past(cfg_ff[0]))
    else $error("capture trigger mismatch");
  evin_gate_a: assert property (!ena_ff[5] && !flg_ff[5] |=> !flg_ff[5])
    else $error("disabled input flag set");
  bat_flag_a: assert property (ena_ff[3] && BAT_DROP |=> flg_ff[3])
    else $error("battery drop flag not set");
  tmp_flag_a: assert property (ena_ff[2] && TMP_DROP |=> flg_ff[2])
    else $error("compensation drop flag not set");
  tmp_gate_a: assert property (!ena_ff[2] && !flg_ff[2] |=> !flg_ff[2])
    else $error("disabled compensation flag set");
  bat_gate_a: assert property (!ena_ff[3] && !flg_ff[3] |=> !flg_ff[3])
    else $error("disabled battery flag set");
  multi_act_a: assert property (cmd_go && cfg_ff[7] && cfg_ff[0] |=>
    evc_ff[0] == 6'h00 && STAMP1_TRIG) else $error("combined command incomplete");
endmodule // cte_top
`default_nettype wire

// ===== hdl/cte_consts.svh
`ifndef CTE_CONSTS_SVH
`define CTE_CONSTS_SVH
// register indices, byte address is four times the index
`define CTE_IDX_CFG 8'h41
`define CTE_IDX_STB 8'h42
`define CTE_IDX_ENA 8'h43
`define CTE_IDX_FLG 8'h47
// extra registers, byte addresses
`define CTE_A_CNT 12'h120
`define CTE_A_BST 12'h124
`define CTE_A_BIF 12'h128
`define CTE_A_BCN 12'h12C
`define CTE_A_IST 12'h200
`define CTE_A_ICL 12'h204
`define CTE_A_IEN 12'h208
// reset value and writable masks
`define CTE_RST8 8'h00
`define CTE_CFG_MASK 8'hF1
`define CTE_ENA_MASK 8'hEF
`define CTE_FLG_MASK 8'hEF
// configuration fields
`define CTE_B_CNTCLR 7
`define CTE_B_BUFCLR 4
`define CTE_B_STAMP 0
// enable and flag fields
`define CTE_B_EVIN 5
`define CTE_B_BAT 3
`define CTE_B_TMP 2
// interrupt status fields
`define CTE_I_EVT 0
`define CTE_I_CMD 1
`define CTE_I_BUF 2
// cycles spent writing stamp data into the first buffer
`define CTE_STAMP_CYC 8
// bus responses
`define CTE_RESP_OK 2'b00
`define CTE_RESP_DEC 2'b11
`endif

// ===== hdl/cte_pkg.sv
`default_nettype none
package cte_pkg;
  // command sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLEAR = 2'b01,
    ST_STAMP = 2'b10
  } cte_state_t;
endpackage
`default_nettype wire

// ===== hdl/cte_reg_if.sv
`default_nettype none
// register access between bus slave and register bank
interface cte_reg_if;
  logic wr_en; // one-cycle write pulse
  logic [11:0] wr_addr; // write byte address
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // write byte lanes
  logic wr_ok; // write address is mapped
  logic [11:0] rd_addr; // read byte address
  logic [31:0] rd_data; // read data
  logic rd_ok; // read address is mapped
  modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
              input wr_ok, rd_data, rd_ok);
  modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ===== hdl/cte_axil.sv
`include "cte_consts.svh"
`default_nettype none
module cte_axil (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write address
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  cte_reg_if.bus rif
);
  logic aw_ff; // write address held
  logic w_ff; // write data held
  logic [11:0] awa_ff; // held write address
  logic [31:0] wd_ff; // held write data
  logic [3:0] ws_ff; // held byte lanes
  logic bv_ff; // response pending
  logic [1:0] br_ff; // response code
  logic rv_ff; // read data pending
  logic [1:0] rr_ff; // read response code
  logic [31:0] rd_ff; // read data

  // each channel accepts one item until the response is gone
  assign awready = !aw_ff && !bv_ff;
  assign wready = !w_ff && !bv_ff;
  assign arready = !rv_ff;
  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign rvalid = rv_ff;
  assign rresp = rr_ff;
  assign rdata = rd_ff;
  // write fires once both halves are held
  assign rif.wr_en = aw_ff && w_ff && !bv_ff;
  assign rif.wr_addr = awa_ff;
  assign rif.wr_data = wd_ff;
  assign rif.wr_strb = ws_ff;
  assign rif.rd_addr = araddr;

  // write channels, in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= `CTE_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_ff <= 1'b1;
        awa_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (rif.wr_en) begin
        // unmapped addresses answer decode error
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= rif.wr_ok ? `CTE_RESP_OK : `CTE_RESP_DEC;
      end else if (bv_ff && bready) begin
        bv_ff <= 1'b0;
      end
    end
  end

  // read channel, data sampled at the address handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rv_ff <= 1'b0;
      rr_ff <= `CTE_RESP_OK;
      rd_ff <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rv_ff <= 1'b1;
      rr_ff <= rif.rd_ok ? `CTE_RESP_OK : `CTE_RESP_DEC;
      rd_ff <= rif.rd_data;
    end else if (rv_ff && rready) begin
      rv_ff <= 1'b0;
    end
  end
endmodule // cte_axil
`default_nettype wire

// ===== hdl/cte_buf.sv
`default_nettype none
module cte_buf #(
  parameter int PW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr, // command clear of full, empty and overwrite flags and pointer
  input wire logic wr, // one entry written
  input wire logic [PW-1:0] int_cnt, // entries per interrupt flag
  input wire logic intf_clr, // software clear of interrupt flag
  // status
  output logic [PW-1:0] ptr,
  output logic full,
  output logic empty,
  output logic ovw,
  output logic intf,
  output logic intf_set
);
  logic [PW-1:0] ptr_ff; // event pointer
  logic full_ff; // buffer full flag
  logic empty_ff; // buffer empty flag
  logic ovw_ff; // overwrite flag
  logic [PW-1:0] ent_ff; // entries since last interrupt flag
  logic intf_ff; // interrupt flag

  assign ptr = ptr_ff;
  assign full = full_ff;
  assign empty = empty_ff;
  assign ovw = ovw_ff;
  assign intf = intf_ff;
  // flag raised when the configured count is reached
  // a count of zero never raises the flag
  assign intf_set = wr && int_cnt != '0 && (ent_ff + 1'b1 == int_cnt);

  // pointer and buffer flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      ovw_ff <= 1'b0;
    end else if (clr) begin
      // back to the empty state
      ptr_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      ovw_ff <= 1'b0;
    end else if (wr) begin
      // writing into a full buffer overwrites the oldest entry
      ptr_ff <= ptr_ff + 1'b1;
      empty_ff <= 1'b0;
      if (&ptr_ff) full_ff <= 1'b1;
      if (full_ff) ovw_ff <= 1'b1;
    end
  end

  // interrupt counting, set wins over software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ent_ff <= '0;
      intf_ff <= 1'b0;
    end else begin
      if (clr) ent_ff <= '0;
      else if (intf_set) ent_ff <= '0;
      else if (wr) ent_ff <= ent_ff + 1'b1;
      if (intf_set) intf_ff <= 1'b1;
      else if (intf_clr) intf_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  buf_intf_a: assert property (intf_set |=> intf && ent_ff == '0)
    else $error("interrupt flag not set at count");
endmodule // cte_buf
`default_nettype wire

// ===== hdl/cte_top_end.sv
`default_nettype none
`default_nettype wire

// ===== bench/tb.sv
`include "cte_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // byte addresses of the mapped registers
  localparam logic [11:0] A_CFG = {2'h0, `CTE_IDX_CFG, 2'h0};
  localparam logic [11:0] A_STB = {2'h0, `CTE_IDX_STB, 2'h0};
  localparam logic [11:0] A_ENA = {2'h0, `CTE_IDX_ENA, 2'h0};
  localparam logic [11:0] A_FLG = {2'h0, `CTE_IDX_FLG, 2'h0};
  // design inputs and outputs
  logic CLK = 1'b0, RST = 1'b1;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, STAMP1_TRIG, IRQ;
  logic [1:0] BRESP, RRESP;
  logic [2:0] EVT_IN = 3'h0;
  logic BAT_DROP = 1'b0, TMP_DROP = 1'b0, VDD_DROP = 1'b0, OSC_STOP = 1'b0;
  logic STAMP2_TRIG = 1'b0, STAMP3_TRIG = 1'b0;
  // bookkeeping
  int error_cnt = 0, comparisons = 0, cyc = 0, stamps = 0, s0;
  logic [31:0] d;
  logic [1:0] r;
  cte_top #(.STAMP_CYC(8)) u_cte_top (.CLK(CLK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .EVT_IN(EVT_IN), .BAT_DROP(BAT_DROP), .TMP_DROP(TMP_DROP),
    .VDD_DROP(VDD_DROP), .OSC_STOP(OSC_STOP), .STAMP2_TRIG(STAMP2_TRIG),
    .STAMP3_TRIG(STAMP3_TRIG), .STAMP1_TRIG(STAMP1_TRIG), .IRQ(IRQ));
  // 100 MHz clock
  initial begin
    forever #5 CLK = ~CLK;
  end
  // count capture pulses and cut a hang short
  always @(posedge CLK) begin
    cyc++;
    if (STAMP1_TRIG === 1'b1) stamps++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // bus write: ready is sampled mid-cycle, which equals its value at the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ra, rw, rb;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(negedge CLK);
      ra = AWREADY;
      rw = WREADY;
      rb = BVALID;
      @(posedge CLK);
      if (ra) AWVALID <= 1'b0;
      if (rw) WVALID <= 1'b0;
      if (rb) break;
    end
    chk({30'h0, BRESP}, {30'h0, `CTE_RESP_OK});
  endtask
  // bus read
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ra, rv;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(negedge CLK);
      ra = ARREADY;
      rv = RVALID;
      v = RDATA;
      rs = RRESP;
      @(posedge CLK);
      if (ra) ARVALID <= 1'b0;
      if (rv) break;
    end
  endtask
  // read and compare
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask
  // one event on every source
  task automatic ev();
    EVT_IN <= 3'h7;
    {BAT_DROP, TMP_DROP, VDD_DROP, OSC_STOP} <= 4'hF;
    @(posedge CLK);
    EVT_IN <= 3'h0;
    {BAT_DROP, TMP_DROP, VDD_DROP, OSC_STOP} <= 4'h0;
    repeat (3) @(posedge CLK);
  endtask
  // interrupt line after it settles
  task automatic irq_is(input logic e);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, IRQ}, {31'h0, e});
    @(posedge CLK);
  endtask
  // poll the strobe until it returns to zero
  task automatic poll();
    int n;
    n = 0;
    d = 32'h1;
    while (d !== 32'h0 && n < 50) begin
      rd(A_STB, d, r);
      n++;
    end
    chk(d, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rc(A_CFG, 32'h0);
    rc(A_STB, 32'h0);
    rc(A_ENA, 32'h0);
    rc(A_FLG, 32'h0);
    wr(A_CFG, 32'hFF);
    rc(A_CFG, 32'hF1);
    wr(A_ENA, 32'hFF);
    rc(A_ENA, 32'hEF);
    rd(12'h3F0, d, r);
    chk({d[29:0], r}, {30'h0, `CTE_RESP_DEC});
    wr(A_ENA, 32'h0);
    ev();
    rc(A_FLG, 32'h0);
    wr(A_ENA, 32'hEF);
    ev();
    rc(A_FLG, 32'hEF);
    wr(`CTE_A_IEN, 32'h1);
    irq_is(1'b1);
    wr(`CTE_A_IEN, 32'h0);
    irq_is(1'b0);
    wr(A_FLG, 32'h0);
    wr(`CTE_A_ICL, 32'h7);
    wr(`CTE_A_IEN, 32'h7);
    irq_is(1'b0);
    // counter clear only, no capture
    ev();
    wr(A_CFG, 32'h80);
    wr(`CTE_A_ICL, 32'h7);
    s0 = stamps;
    wr(A_STB, 32'h0);
    poll();
    rc(`CTE_A_CNT, 32'h0);
    chk(stamps, s0);
    rc(`CTE_A_IST, 32'h2);
    irq_is(1'b1);
    wr(`CTE_A_ICL, 32'h7);
    wr(A_FLG, 32'h0);
    // write two entries into buffer two and one into buffer three
    wr(`CTE_A_BCN, 32'h201);
    STAMP2_TRIG <= 1'b1;
    STAMP3_TRIG <= 1'b1;
    @(posedge CLK);
    STAMP3_TRIG <= 1'b0;
    @(posedge CLK);
    STAMP2_TRIG <= 1'b0;
    repeat (2) @(posedge CLK);
    rd(`CTE_A_BIF, d, r);
    chk(d & 32'h2, 32'h2);
    rc(`CTE_A_BST, 32'h00102100);
    // every action at once, with capture
    ev();
    wr(A_CFG, 32'hF1);
    s0 = stamps;
    // the only capture of the run, so stamp spacing holds
    wr(A_STB, 32'h5A);
    rc(A_STB, 32'h5A);
    poll();
    rc(`CTE_A_BST, 32'h01010001);
    rc(`CTE_A_CNT, 32'h0);
    chk(stamps, s0 + 1);
    // host confirms the capture through the buffer one flag
    rd(`CTE_A_BIF, d, r);
    chk(d & 32'h1, 32'h1);
    complete_run();
  end
endmodule // tb
`default_nettype wire
